// File: core/dac_pkg.sv
// constants and carrier types of the dual dac serial control core
// assumes a 12-bit variant; shared by the core and the bench
package dac_pkg;

  // ********************
  // address
  // ********************
  localparam logic [5:0] ADDR_HI_STD = 6'h06; // 000110
  localparam logic [5:0] ADDR_HI_ALT = 6'h11; // 010001
  localparam logic [5:0] ADDR_HI     = ADDR_HI_STD;

  // ********************
  // data word layout
  // ********************
  localparam int CODE_W   = 12;
  localparam int POS_PD_HI    = 15;
  localparam int POS_PD_LO    = 14;
  localparam int POS_CLEAR_N  = 13;
  localparam int POS_LD   = 12;
  localparam int POS_SELA = 0;
  localparam int POS_SELB = 1;

  // ********************
  // reset and readback values
  // ********************
  localparam logic [15:0] RB_DEFAULT = 16'h2000;
  localparam logic [7:0]  PTR_RESET  = 8'h00;
  localparam logic [1:0]  PD_NORMAL  = 2'h0;
  localparam logic [1:0]  PD_1K      = 2'h1;
  localparam logic [1:0]  PD_100K    = 2'h2;
  localparam logic [1:0]  PD_TRI     = 2'h3;
  localparam logic [3:0]  BIT_ACK    = 4'h8;

  // received data word
  typedef struct packed {
    logic [1:0]        pd;
    logic              clear_all_n;
    logic              load_outputs_n;
    logic [CODE_W-1:0] code;
  } data_word_s;

  // one channel as seen by the analog side
  typedef struct packed {
    logic [1:0]        pd;
    logic [CODE_W-1:0] code;
  } chan_out_s;

  // link states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR  = 3'b010,
    ST_HI   = 3'b011,
    ST_LO   = 3'b100,
    ST_RHI  = 3'b101,
    ST_RLO  = 3'b110
  } link_state_e;

endpackage

// File: core/dual_dac_serial_control.sv
// two-wire slave and double-buffered registers of a dual dac
// assumes scl comes from the bus master; sda is open drain
`timescale 1ns/1ns
module dual_dac_serial_control (
  // system side
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // two-wire link
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // strap
  input  wire logic              address_select_pin,
  // analog side
  output dac_pkg::chan_out_s     dac_a,
  output dac_pkg::chan_out_s     dac_b
);

  // ********************
  // declarations
  // ********************
  logic                  start_tgl_q;
  logic                  stop_tgl_q;
  logic                  start_seen_q;
  logic [1:0]            strap_q;
  dac_pkg::link_state_e  state_q;
  logic [3:0]            bit_q;
  logic [7:0]            sh_q;
  logic                  ack_q;
  logic [7:0]            tx_q;
  logic [7:0]            ptr_q;
  logic [7:0]            hi_q;
  logic [7:0]            lo_q;
  logic                  wr_valid_q;
  logic                  drive_q;
  logic [2:0]            stop_sync_q;
  logic [dac_pkg::CODE_W-1:0] in_a_q;
  logic [dac_pkg::CODE_W-1:0] in_b_q;
  logic                  pend_a_q;
  logic                  pend_b_q;
  logic [7:0]            nb;
  logic                  addr_hit;
  logic                  rd_state;
  logic [15:0]           rb_word;
  logic [1:0]            sel;
  logic                  commit;
  dac_pkg::data_word_s   word;

  // ********************
  // start and stop detection
  // ********************

  // start: sda falls while scl high
  always_ff @(negedge sda_in or negedge resetn) begin
    if (!resetn) begin
      start_tgl_q <= 1'b0;
    end else if (scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // stop: sda rises while scl high
  always_ff @(posedge sda_in or negedge resetn) begin
    if (!resetn) begin
      stop_tgl_q <= 1'b0;
    end else if (scl) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  // ********************
  // link side, scl domain
  // ********************

  // strap pin crosses into scl domain
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      strap_q <= 2'h0;
    end else begin
      strap_q <= {strap_q[0], address_select_pin};
    end
  end

  // byte being completed this edge
  assign nb       = {sh_q[6:0], sda_in};
  assign addr_hit = (nb[7:1] == {dac_pkg::ADDR_HI, strap_q[1]});
  assign rd_state = (state_q == dac_pkg::ST_RHI) || (state_q == dac_pkg::ST_RLO);
  assign sel      = {ptr_q[dac_pkg::POS_SELB], ptr_q[dac_pkg::POS_SELA]};

  // readback word; sys registers only move after a stop, so they
  // are quiet while the link reads them
  always_comb begin
    case (sel)
      2'h1:    rb_word = {dac_a.pd, 2'h2, in_a_q};
      2'h2:    rb_word = {dac_b.pd, 2'h2, in_b_q};
      default: rb_word = dac_pkg::RB_DEFAULT;
    endcase
  end

  // bit engine; a start toggle seen here marks address bit 7, the
  // toggle was set half a clock earlier so it is settled
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      start_seen_q <= 1'b0;
      state_q      <= dac_pkg::ST_IDLE;
      bit_q        <= 4'h0;
      sh_q         <= 8'h00;
      ack_q        <= 1'b0;
      tx_q         <= 8'h00;
      ptr_q        <= dac_pkg::PTR_RESET;
      hi_q         <= 8'h00;
      lo_q         <= 8'h00;
      wr_valid_q   <= 1'b0;
    end else begin
      start_seen_q <= start_tgl_q;
      if (start_tgl_q != start_seen_q) begin
        state_q    <= dac_pkg::ST_ADDR;
        bit_q      <= 4'h1;
        sh_q       <= {7'h00, sda_in};
        ack_q      <= 1'b0;
        wr_valid_q <= 1'b0;
      end else if (state_q == dac_pkg::ST_IDLE) begin
        bit_q <= 4'h0;
        ack_q <= 1'b0;
      end else if (bit_q != dac_pkg::BIT_ACK) begin
        bit_q <= bit_q + 4'h1;
        sh_q  <= nb;
        if (bit_q == 4'h7) begin
          case (state_q)
            dac_pkg::ST_ADDR: begin
              ack_q <= addr_hit;
              if (!addr_hit) begin
                state_q <= dac_pkg::ST_IDLE;
              end
            end
            dac_pkg::ST_PTR: begin
              ptr_q <= nb;
              ack_q <= 1'b1;
            end
            dac_pkg::ST_HI: begin
              hi_q  <= nb;
              ack_q <= 1'b1;
            end
            dac_pkg::ST_LO: begin
              lo_q       <= nb;
              ack_q      <= 1'b1;
              wr_valid_q <= 1'b1;
            end
            default: ack_q <= 1'b0;
          endcase
        end
      end else begin
        // acknowledge clock
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        case (state_q)
          dac_pkg::ST_ADDR: begin
            if (sh_q[0]) begin
              state_q <= dac_pkg::ST_RHI;
              tx_q    <= rb_word[15:8];
            end else begin
              state_q <= dac_pkg::ST_PTR;
            end
          end
          dac_pkg::ST_PTR: state_q <= dac_pkg::ST_HI;
          dac_pkg::ST_HI:  state_q <= dac_pkg::ST_LO;
          dac_pkg::ST_RHI: begin
            state_q <= sda_in ? dac_pkg::ST_IDLE : dac_pkg::ST_RLO;
            tx_q    <= rb_word[7:0];
          end
          dac_pkg::ST_RLO: begin
            state_q <= sda_in ? dac_pkg::ST_IDLE : dac_pkg::ST_RHI;
            tx_q    <= rb_word[15:8];
          end
          default: state_q <= dac_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // sda driven on the falling edge so it is stable across scl high
  always_ff @(negedge scl or negedge resetn) begin
    if (!resetn) begin
      drive_q <= 1'b0;
    end else if (bit_q == dac_pkg::BIT_ACK) begin
      drive_q <= ack_q;
    end else begin
      drive_q <= rd_state && !tx_q[3'h7 - bit_q[2:0]];
    end
  end

  // open drain: the pad only ever pulls low
  always_ff @(negedge scl or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  assign sda_oe = drive_q;

  // ********************
  // register side, sys domain
  // ********************

  // stop event synchronised, third stage only for the edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stop_sync_q <= 3'h0;
    end else begin
      stop_sync_q <= {stop_sync_q[1:0], stop_tgl_q};
    end
  end

  // link word is frozen after a stop until the next start
  assign commit = (stop_sync_q[2] != stop_sync_q[1]) && wr_valid_q;
  assign word   = dac_pkg::data_word_s'({hi_q, lo_q});

  // input, dac and pending registers; clear wins over every code write and load, but pd is still written
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in_a_q   <= '0;
      in_b_q   <= '0;
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
      dac_a    <= '0;
      dac_b    <= '0;
    end else if (commit && sel != 2'h0) begin
      if (sel[0]) begin
        dac_a.pd <= word.pd;
      end
      if (sel[1]) begin
        dac_b.pd <= word.pd;
      end
      if (!word.clear_all_n) begin
        in_a_q     <= '0;
        in_b_q     <= '0;
        dac_a.code <= '0;
        dac_b.code <= '0;
        pend_a_q   <= 1'b0;
        pend_b_q   <= 1'b0;
      end else begin
        if (sel[0]) begin
          in_a_q <= word.code;
        end
        if (sel[1]) begin
          in_b_q <= word.code;
        end
        if (!word.load_outputs_n) begin
          // only channels touched since the last load move
          if (sel[0]) begin
            dac_a.code <= word.code;
          end else if (pend_a_q) begin
            dac_a.code <= in_a_q;
          end
          if (sel[1]) begin
            dac_b.code <= word.code;
          end else if (pend_b_q) begin
            dac_b.code <= in_b_q;
          end
          pend_a_q <= 1'b0;
          pend_b_q <= 1'b0;
        end else begin
          pend_a_q <= pend_a_q | sel[0];
          pend_b_q <= pend_b_q | sel[1];
        end
      end
    end
  end

endmodule // dual_dac_serial_control

// File: test/dual_dac_serial_control_assertions.sv
// port assertions of the dual dac serial control core
// assumes bind into the core; sampled on clk_sys
`timescale 1ns/1ns
module dual_dac_serial_control_assertions (
  // system
  input wire logic               clk_sys,
  input wire logic               resetn,
  // link
  input wire logic               scl,
  input wire logic               sda_in,
  input wire logic               sda_out,
  input wire logic               sda_oe,
  input wire logic               address_select_pin,
  // analog side
  input wire dac_pkg::chan_out_s dac_a,
  input wire dac_pkg::chan_out_s dac_b
);
  // ***
  // bus events
  // ***
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [1:0] line_q;
  logic       idle_q;
  logic [3:0] since_q;
  wire        stop_w  = scl && line_q == 2'h2 && sda_in;
  wire        start_w = scl && line_q == 2'h3 && !sda_in;
  // scl half period beats clk_sys, so no level is missed
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) line_q <= 2'h3;
    else line_q <= {scl, sda_in};
  end
  // idle from stop to next start
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) idle_q <= 1'b1;
    else if (start_w) idle_q <= 1'b0;
    else if (stop_w) idle_q <= 1'b1;
  end
  // cycles since stop, saturating
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) since_q <= 4'hF;
    else if (stop_w) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  sequence start_s;
    scl && sda_in ##1 scl && !sda_in;
  endsequence
  drain_low_a: assert property (!sda_out)
    else $error("sda out high");
  oe_steady_a: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("drive moved, scl high");
  start_quiet_a: assert property (start_s |-> !sda_oe [*8])
    else $error("drive after start");
  idle_quiet_a: assert property (idle_q |-> !sda_oe)
    else $error("drive while idle");
  reset_zero_a: assert property ($rose(resetn) |-> {dac_a, dac_b} == 28'h0)
    else $error("dac not zero");
  reset_quiet_a: assert property ($rose(resetn) |-> !sda_oe [*4])
    else $error("drive after reset");
  chan_a_commit_a: assert property ($changed(dac_a) |-> since_q <= 4'h6)
    else $error("a moved, no stop");
  chan_b_commit_a: assert property ($changed(dac_b) |-> since_q <= 4'h6)
    else $error("b moved, no stop");
endmodule // dual_dac_serial_control_assertions
bind dual_dac_serial_control dual_dac_serial_control_assertions
  dual_dac_serial_control_assertions_i (.clk_sys, .resetn, .scl, .sda_in,
  .sda_out, .sda_oe, .address_select_pin, .dac_a, .dac_b);

// File: test/i2c_master_model.sv
// two-wire bus master model
// assumes a pull-up on sda; scl stands high between frames
`timescale 1ns/1ns
module i2c_master_model (
  // bus lines
  output logic      scl,
  output logic      pull_low,
  input  wire logic sda
);
  // ***
  // bus tasks
  // ***
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // 48 ns bit: sda moves only in the low half
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    #6 pull_low = !b;
    #18 scl = 1'b1;
    #12 r = sda;
    #12;
  endtask
  // start or repeated start
  task automatic start();
    logic r;
    bit_x(1'b1, r);
    pull_low = 1'b1;
    #24;
  endtask
  // stop, then idle
  task automatic stop();
    logic r;
    bit_x(1'b0, r);
    pull_low = 1'b0;
    #24;
  endtask
  // byte out, msb first; k is the slave ack
  task automatic send(input logic [7:0] d, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    k = !r;
  endtask
  // byte in; ack only when more is wanted
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!more, r);
  endtask
  // address, pointer, two data bytes, stop
  task automatic write_frame(input logic [6:0] a, input logic [7:0] p,
                             input logic [15:0] w, output logic [3:0] k);
    start();
    send({a, 1'b0}, k[3]);
    send(p, k[2]);
    send(w[15:8], k[1]);
    send(w[7:0], k[0]);
    stop();
  endtask
  // optional pointer, then n byte pairs; last pair kept
  task automatic read_frame(input logic [6:0] a, input logic pe, input logic [7:0] p,
                            input int n, output logic [15:0] w, output logic k);
    logic r;
    start();
    if (pe) begin
      send({a, 1'b0}, r);
      send(p, r);
      start();
    end
    send({a, 1'b1}, k);
    for (int i = 1; i <= n; i++) begin
      recv(1'b1, w[15:8]);
      recv(i < n, w[7:0]);
    end
    stop();
  endtask
endmodule // i2c_master_model

// File: test/test_dual_dac_serial_control.sv
// self-checking bench of the dual dac serial control core
// assumes the master model and bound checker are compiled
`timescale 1ns/1ns
module test_dual_dac_serial_control;
  // ***
  // harness
  // ***
  logic clk_sys, resetn, strap_pin, scl, pull_low, sda_out, sda_oe;
  dac_pkg::chan_out_s dac_a, dac_b;
  int bad_count, compares;
  localparam logic [6:0] ADR = {dac_pkg::ADDR_HI, 1'b0};
  localparam logic [6:0] ADR1 = {dac_pkg::ADDR_HI, 1'b1};
  // open drain: released sda reads high
  wire sda = !(pull_low || (sda_oe && !sda_out));
  dual_dac_serial_control dual_dac_serial_control_i (.clk_sys, .resetn, .scl,
    .sda_in(sda), .sda_out, .sda_oe, .address_select_pin(strap_pin), .dac_a, .dac_b);
  i2c_master_model i2c_master_model_i (.scl, .pull_low, .sda);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = !clk_sys;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic dacs(input logic [13:0] ea, input logic [13:0] eb);
    chk({2'h0, dac_a}, {2'h0, ea});
    chk({2'h0, dac_b}, {2'h0, eb});
  endtask
  // commit lands a few clk_sys cycles after stop
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] w,
                    input logic [3:0] ek);
    logic [3:0] k;
    i2c_master_model_i.write_frame(a, p, w, k);
    repeat (8) @(posedge clk_sys);
    chk({12'h000, k}, {12'h000, ek});
  endtask
  task automatic rd(input logic pe, input logic [7:0] p, input logic [15:0] e);
    logic [15:0] w;
    logic k;
    i2c_master_model_i.read_frame(ADR, pe, p, 3, w, k);
    chk({15'h0000, k}, 16'h0001);
    chk(w, e);
  endtask
  task automatic t_power_on();
    dacs(14'h0000, 14'h0000);
    rd(1'b0, 8'h00, dac_pkg::RB_DEFAULT);
    $display("power-on done");
  endtask
  task automatic t_buffers();
    wr(ADR, 8'hC1, 16'h3123, 4'hF);
    dacs(14'h0000, 14'h0000);
    rd(1'b1, 8'h01, 16'h2123);
    wr(ADR, 8'h02, 16'h2456, 4'hF);
    dacs(14'h0123, 14'h0456);
    wr(ADR, 8'h01, 16'h2789, 4'hF);
    dacs(14'h0789, 14'h0456);
    $display("buffers done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(ADR, 8'h03, {m[1:0], 14'h2ABC}, 4'hF);
      dacs({m[1:0], 12'hABC}, {m[1:0], 12'hABC});
    end
    wr(ADR, 8'h01, 16'h70F0, 4'hF);
    dacs(14'h1ABC, 14'h3ABC);
    rd(1'b1, 8'h03, dac_pkg::RB_DEFAULT);
    $display("modes done");
  endtask
  task automatic t_clear();
    wr(ADR, 8'h02, 16'h1555, 4'hF);
    dacs(14'h1000, 14'h0000);
    rd(1'b1, 8'h02, 16'h2000);
    $display("clear done");
  endtask
  task automatic t_refuse();
    wr(ADR, 8'h00, 16'h2FFF, 4'hF);
    wr(ADR1, 8'h03, 16'h2FFF, 4'h0);
    dacs(14'h1000, 14'h0000);
    @(posedge clk_sys);
    #2 strap_pin = 1'b1;
    wr(ADR, 8'h03, 16'h2FFF, 4'h0);
    wr(ADR1, 8'h03, 16'h2321, 4'hF);
    dacs(14'h0321, 14'h0321);
    $display("refuse done");
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    strap_pin = 1'b0;
    repeat (6) @(posedge clk_sys);
    #2 resetn = 1'b1;
    t_power_on();
    t_buffers();
    t_modes();
    t_clear();
    t_refuse();
    finish_test();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end
endmodule // test_dual_dac_serial_control
